// [intc_pkg.sv]
// package: register map, field layout and types for mode/cpu priority control
package intc_pkg;
  localparam logic [3:0] ADDR_MODE_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CPU_PRIO = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  localparam logic [3:0] ADDR_ARB_STATE = 4'h4;

  localparam int MODE_HI = 5;
  localparam int MODE_LO = 4;
  localparam int NMI_EDGE_BIT = 3;
  localparam logic [7:0] MODE_CTRL_WMASK = 8'h38;

  localparam int PCE_BIT = 7;
  localparam int XFER_HI = 6;
  localparam int XFER_LO = 4;
  localparam int AUTO_BIT = 3;
  localparam int CPU_HI = 2;
  localparam int CPU_LO = 0;

  localparam logic [1:0] MODE_0 = 2'h0;
  localparam logic [1:0] MODE_2 = 2'h2;
  localparam logic [2:0] LEVEL_MIN = 3'h0;
  localparam logic [2:0] LEVEL_MAX = 3'h7;
  localparam logic [3:0] LEVEL_ALWAYS = 4'h8;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  localparam int NUM_DMA_CH = 4;
  localparam int NUM_EVT = 3;
  localparam int EVT_NMI = 0;
  localparam int EVT_BAD_MODE = 1;
  localparam int EVT_CPU_WIN = 2;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic ccr_mask;
    logic [2:0] exr_mask;
  } cpu_mask_s;

  typedef struct packed {
    logic illegal;
    logic trace;
    logic trap;
    logic cpu_addr_err;
    logic dma_addr_err;
  } exc_s;
endpackage

// [intc_edge_detect.sv]
// selectable rising/falling edge detector for the nonmaskable pin
`timescale 1ns/1ns
module intc_edge_detect (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_pin,
  input wire logic i_rising,
  output logic o_pulse
);
  logic prev;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      prev <= 1'b0;
    end else begin
      prev <= i_pin;
    end
  end

  // prev resets low, so a falling edge cannot fire until the pin was high
  assign o_pulse = i_rising ? (i_pin & ~prev) : (~i_pin & prev);
endmodule

// [intc_level_cmp.sv]
// one arbitration point: cpu wins only on a strictly higher level
`timescale 1ns/1ns
module intc_level_cmp (
  input wire logic i_enable,
  input wire logic [2:0] i_cpu_level,
  input wire logic [2:0] i_other_level,
  output logic o_cpu_wins
);
  // a tie favours the transfer side so transfers are never starved by it
  assign o_cpu_wins = i_enable & (i_cpu_level > i_other_level);
endmodule

// [intc_mode_prio.sv]
// top: interrupt mode control and cpu arbitration priority registers
`timescale 1ns/1ns
module intc_mode_prio (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  input wire logic I_NMI_PIN,
  input wire logic I_CCR_MASK,
  input wire logic [2:0] I_EXR_MASK,
  input wire logic I_EXC_ILLEGAL,
  input wire logic I_EXC_TRACE,
  input wire logic I_EXC_TRAP,
  input wire logic I_EXC_CPU_ADDR_ERR,
  input wire logic I_EXC_DMA_ADDR_ERR,
  input wire logic [11:0] I_DMA_CH_LEVELS,
  output logic [1:0] O_MODE,
  output logic O_MODE0,
  output logic O_MODE2,
  output logic O_NMI_REQ,
  output logic O_ALWAYS_ACCEPT,
  output logic [3:0] O_ACCEPT_LEVEL,
  output logic [2:0] O_CPU_LEVEL,
  output logic [2:0] O_XFER_LEVEL,
  output logic O_CPU_OVER_XFER,
  output logic [3:0] O_CPU_OVER_DMA,
  output logic O_IRQ
);
  intc_pkg::reg_req_s req;
  intc_pkg::cpu_mask_s mask_in;
  intc_pkg::exc_s exc;
  logic [7:0] mode_ctrl;
  logic [7:0] cpu_prio;
  logic [intc_pkg::NUM_EVT-1:0] irq_status;
  logic [intc_pkg::NUM_EVT-1:0] irq_mask;
  logic [intc_pkg::NUM_EVT-1:0] events;
  logic [1:0] mode;
  logic prio_enable;
  logic auto_set;
  logic [2:0] cpu_mask_level;
  logic [2:0] next_cpu_level;
  logic [2:0] cpu_level;
  logic [2:0] xfer_level;
  logic nmi_pulse;
  logic cpu_over_xfer;
  logic [intc_pkg::NUM_DMA_CH-1:0] cpu_over_dma;
  logic cpu_over_xfer_prev;
  logic bad_mode;
  logic [7:0] next_rdata;

  assign req = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
  assign mask_in = '{ccr_mask: I_CCR_MASK, exr_mask: I_EXR_MASK};
  assign exc = '{illegal: I_EXC_ILLEGAL, trace: I_EXC_TRACE,
                 trap: I_EXC_TRAP, cpu_addr_err: I_EXC_CPU_ADDR_ERR,
                 dma_addr_err: I_EXC_DMA_ADDR_ERR};

  assign mode = mode_ctrl[intc_pkg::MODE_HI:intc_pkg::MODE_LO];
  assign prio_enable = cpu_prio[intc_pkg::PCE_BIT];
  assign auto_set = cpu_prio[intc_pkg::AUTO_BIT];
  assign cpu_level = cpu_prio[intc_pkg::CPU_HI:intc_pkg::CPU_LO];
  assign xfer_level = cpu_prio[intc_pkg::XFER_HI:intc_pkg::XFER_LO];

  // mode control register: only mode and edge bits are storage
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      mode_ctrl <= intc_pkg::RESET_BYTE;
    end else if (req.wr && req.addr == intc_pkg::ADDR_MODE_CTRL) begin
      mode_ctrl <= req.wdata & intc_pkg::MODE_CTRL_WMASK;
    end
  end

  // cpu mask expressed as a level; mode 0 maps a set mask bit to top
  always_comb begin
    unique case (mode)
      intc_pkg::MODE_0: begin
        cpu_mask_level = mask_in.ccr_mask ? intc_pkg::LEVEL_MAX
                                          : intc_pkg::LEVEL_MIN;
      end
      intc_pkg::MODE_2: begin
        cpu_mask_level = mask_in.exr_mask;
      end
      default: begin
        // prohibited codes: fall back to the single-bit behaviour
        cpu_mask_level = mask_in.ccr_mask ? intc_pkg::LEVEL_MAX
                                          : intc_pkg::LEVEL_MIN;
      end
    endcase
  end

  always_comb begin
    next_cpu_level = cpu_level;
    if (auto_set) begin
      next_cpu_level = cpu_mask_level;
    end else if (req.wr && req.addr == intc_pkg::ADDR_CPU_PRIO &&
                 !req.wdata[intc_pkg::AUTO_BIT]) begin
      next_cpu_level = req.wdata[intc_pkg::CPU_HI:intc_pkg::CPU_LO];
    end
    // writing auto=1 this cycle locks out the written level already
  end

  // while auto is set the written cpu level bits are dropped
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      cpu_prio <= intc_pkg::RESET_BYTE;
    end else begin
      if (req.wr && req.addr == intc_pkg::ADDR_CPU_PRIO) begin
        cpu_prio[intc_pkg::PCE_BIT:intc_pkg::AUTO_BIT] <=
          req.wdata[intc_pkg::PCE_BIT:intc_pkg::AUTO_BIT];
      end
      cpu_prio[intc_pkg::CPU_HI:intc_pkg::CPU_LO] <= next_cpu_level;
    end
  end

  intc_edge_detect u_nmi_edge (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_pin(I_NMI_PIN),
    .i_rising(mode_ctrl[intc_pkg::NMI_EDGE_BIT]),
    .o_pulse(nmi_pulse)
  );

  // cpu compares its level only when the enable bit is set
  intc_level_cmp u_cmp_xfer (
    .i_enable(prio_enable),
    .i_cpu_level(cpu_level),
    .i_other_level(xfer_level),
    .o_cpu_wins(cpu_over_xfer)
  );

  genvar ch;
  generate
    for (ch = 0; ch < intc_pkg::NUM_DMA_CH; ch++) begin : g_dma
      intc_level_cmp u_cmp_dma (
        .i_enable(prio_enable),
        .i_cpu_level(cpu_level),
        .i_other_level(I_DMA_CH_LEVELS[ch*3 +: 3]),
        .o_cpu_wins(cpu_over_dma[ch])
      );
    end
  endgenerate

  assign bad_mode = req.wr && req.addr == intc_pkg::ADDR_MODE_CTRL &&
                    req.wdata[intc_pkg::MODE_LO];

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      cpu_over_xfer_prev <= 1'b0;
    end else begin
      cpu_over_xfer_prev <= cpu_over_xfer;
    end
  end

  always_comb begin
    events = '0;
    events[intc_pkg::EVT_NMI] = nmi_pulse;
    events[intc_pkg::EVT_BAD_MODE] = bad_mode;
    events[intc_pkg::EVT_CPU_WIN] = cpu_over_xfer & ~cpu_over_xfer_prev;
  end

  // sticky status: a new event beats a write-one clear in the same cycle
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      irq_status <= '0;
    end else if (req.wr && req.addr == intc_pkg::ADDR_IRQ_STATUS) begin
      irq_status <= (irq_status & ~req.wdata[intc_pkg::NUM_EVT-1:0]) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      irq_mask <= '0;
    end else if (req.wr && req.addr == intc_pkg::ADDR_IRQ_MASK) begin
      irq_mask <= req.wdata[intc_pkg::NUM_EVT-1:0];
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    unique case (req.addr)
      intc_pkg::ADDR_MODE_CTRL: next_rdata = mode_ctrl;
      intc_pkg::ADDR_CPU_PRIO: next_rdata = cpu_prio;
      intc_pkg::ADDR_IRQ_STATUS: next_rdata = {5'h00, irq_status};
      intc_pkg::ADDR_IRQ_MASK: next_rdata = {5'h00, irq_mask};
      intc_pkg::ADDR_ARB_STATE: next_rdata = {3'h0, cpu_over_dma,
                                              cpu_over_xfer};
      default: next_rdata = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_RDATA <= 8'h00;
    end else if (req.rd) begin
      O_RDATA <= next_rdata;
    end else begin
      O_RDATA <= 8'h00;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_NMI_REQ <= 1'b0;
      O_ALWAYS_ACCEPT <= 1'b0;
    end else begin
      O_NMI_REQ <= nmi_pulse;
      O_ALWAYS_ACCEPT <= nmi_pulse | (|exc);
    end
  end

  assign O_MODE = mode;
  assign O_MODE0 = (mode == intc_pkg::MODE_0);
  assign O_MODE2 = (mode == intc_pkg::MODE_2);
  assign O_ACCEPT_LEVEL = O_ALWAYS_ACCEPT ? intc_pkg::LEVEL_ALWAYS
                                          : {1'b0, cpu_mask_level};
  assign O_CPU_LEVEL = cpu_level;
  assign O_XFER_LEVEL = xfer_level;
  assign O_CPU_OVER_XFER = cpu_over_xfer;
  assign O_CPU_OVER_DMA = cpu_over_dma;
  assign O_IRQ = |(irq_status & irq_mask);
endmodule

// [intc_mode_prio_asserts.sv]
// checker: port-level relations of the mode and cpu priority block
`timescale 1ns/1ns
module intc_mode_prio_asserts (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [3:0] I_ADDR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  input wire logic I_NMI_PIN,
  input wire logic I_CCR_MASK,
  input wire logic I_EXC_TRAP,
  input wire logic [11:0] I_DMA_CH_LEVELS,
  input wire logic [1:0] O_MODE,
  input wire logic O_MODE0,
  input wire logic O_MODE2,
  input wire logic O_NMI_REQ,
  input wire logic O_ALWAYS_ACCEPT,
  input wire logic [3:0] O_ACCEPT_LEVEL,
  input wire logic [2:0] O_CPU_LEVEL,
  input wire logic [2:0] O_XFER_LEVEL,
  input wire logic O_CPU_OVER_XFER,
  input wire logic [3:0] O_CPU_OVER_DMA
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  AST_RESV_ZERO: assert property ($past(I_RD && I_ADDR == 4'h0) |->
    O_RDATA[7:6] == 2'h0 && O_RDATA[2:0] == 3'h0) else $error("resv bits");
  AST_MODE0: assert property (O_MODE == 2'h0 |-> O_MODE0 && !O_MODE2)
    else $error("mode 0 decode");
  AST_MODE2: assert property (O_MODE == 2'h2 |-> O_MODE2 && !O_MODE0)
    else $error("mode 2 decode");
  AST_ACC_M0: assert property (!O_ALWAYS_ACCEPT && O_MODE == 2'h0 |->
    O_ACCEPT_LEVEL == (I_CCR_MASK ? 4'h7 : 4'h0)) else $error("mode 0 lvl");
  AST_EXC: assert property (I_EXC_TRAP |=>
    O_ALWAYS_ACCEPT && O_ACCEPT_LEVEL == 4'h8) else $error("exc level");
  AST_NMI: assert property (O_NMI_REQ |->
    ($past(I_NMI_PIN) != $past(I_NMI_PIN, 2) ||
    $past(I_NMI_PIN, 2) != $past(I_NMI_PIN, 3)) ##1 !O_NMI_REQ)
    else $error("nmi pulse");
  AST_XFER: assert property (O_CPU_OVER_XFER |->
    O_CPU_LEVEL > O_XFER_LEVEL) else $error("xfer grant");
  AST_DMA: assert property (O_CPU_OVER_DMA[3] |->
    O_CPU_LEVEL > I_DMA_CH_LEVELS[11:9]) else $error("dma grant");
endmodule
bind intc_mode_prio intc_mode_prio_asserts chk (.*);

// [cpu_side_model.sv]
// far-side model: cpu mask, exceptions, nmi pin and dma channel levels
`timescale 1ns/1ns
module cpu_side_model (
  input wire logic i_clk,
  output intc_pkg::cpu_mask_s o_mask,
  output intc_pkg::exc_s o_exc,
  output logic o_nmi,
  output logic [11:0] o_dma
);
  initial begin
    o_mask = '0;
    o_exc = '0;
    o_nmi = 1'b0;
    o_dma = 12'h000;
  end
  task automatic set_mask(input logic c, input logic [2:0] e);
    @(posedge i_clk);
    o_mask <= {c, e};
  endtask
  // channel levels live in the dma side, the block only compares them
  task automatic set_dma(input logic [11:0] v);
    @(posedge i_clk);
    o_dma <= v;
  endtask
  task automatic set_nmi(input logic v);
    @(posedge i_clk);
    o_nmi <= v;
  endtask
  task automatic fault(input int i);
    @(posedge i_clk);
    o_exc <= 5'h01 << i;
    @(posedge i_clk);
    o_exc <= '0;
  endtask
endmodule

// [intc_mode_and_cpu_priority_bench.sv]
// self-checking bench for the mode and cpu priority block
`timescale 1ns/1ns
module intc_mode_and_cpu_priority_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  intc_pkg::reg_req_s req = '0;
  intc_pkg::cpu_mask_s mask;
  intc_pkg::exc_s exc;
  logic [11:0] dma;
  logic [7:0] rdata;
  logic [3:0] alvl, od;
  logic [2:0] clvl, xlvl;
  logic [1:0] mode;
  logic nmi, m0, m2, nreq, acc, ox, irq;
  int n_errors = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  cpu_side_model far (.i_clk(clk), .o_mask(mask), .o_exc(exc), .o_nmi(nmi),
    .o_dma(dma));
  intc_mode_prio uut (.I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(req.addr),
    .I_WDATA(req.wdata), .I_WR(req.wr), .I_RD(req.rd), .O_RDATA(rdata),
    .I_NMI_PIN(nmi), .I_CCR_MASK(mask.ccr_mask), .I_EXR_MASK(mask.exr_mask),
    .I_EXC_ILLEGAL(exc.illegal), .I_EXC_TRACE(exc.trace),
    .I_EXC_TRAP(exc.trap), .I_EXC_CPU_ADDR_ERR(exc.cpu_addr_err),
    .I_EXC_DMA_ADDR_ERR(exc.dma_addr_err), .I_DMA_CH_LEVELS(dma),
    .O_MODE(mode), .O_MODE0(m0), .O_MODE2(m2), .O_NMI_REQ(nreq),
    .O_ALWAYS_ACCEPT(acc), .O_ACCEPT_LEVEL(alvl), .O_CPU_LEVEL(clvl),
    .O_XFER_LEVEL(xlvl), .O_CPU_OVER_XFER(ox), .O_CPU_OVER_DMA(od),
    .O_IRQ(irq));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= {a, d, 2'b10};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    req <= {a, 8'h00, 2'b01};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic pulses(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    repeat (4) begin
      @(posedge clk);
      #1 if (nreq === 1'b1) n++;
    end
    chk(n, exp);
  endtask
  task automatic t_reset;
    rd(intc_pkg::ADDR_MODE_CTRL, 8'h00);
    rd(intc_pkg::ADDR_CPU_PRIO, 8'h00);
    rd(4'hF, 8'h00);
    chk({7'h00, irq}, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_mode;
    wr(intc_pkg::ADDR_MODE_CTRL, 8'hEF);
    rd(intc_pkg::ADDR_MODE_CTRL, 8'h28);
    chk({6'h00, m0, m2}, 8'h01);
    chk({6'h00, mode}, 8'h02);
    wr(intc_pkg::ADDR_MODE_CTRL, 8'h00);
    far.set_mask(1'b1, 3'h0);
    #1 chk({6'h00, m0, m2}, 8'h02);
    chk({4'h0, alvl}, 8'h07);
    $display("test mode done");
  endtask
  // the prohibited mode write is made on purpose to raise the event
  task automatic t_irq;
    wr(intc_pkg::ADDR_IRQ_MASK, 8'h02);
    wr(intc_pkg::ADDR_MODE_CTRL, 8'h10);
    #1 chk({7'h00, irq}, 8'h01);
    wr(intc_pkg::ADDR_IRQ_MASK, 8'h00);
    #1 chk({7'h00, irq}, 8'h00);
    rd(intc_pkg::ADDR_IRQ_STATUS, 8'h02);
    wr(intc_pkg::ADDR_IRQ_STATUS, 8'h02);
    rd(intc_pkg::ADDR_IRQ_STATUS, 8'h00);
    wr(intc_pkg::ADDR_MODE_CTRL, 8'h00);
    $display("test irq done");
  endtask
  task automatic t_nmi;
    far.set_nmi(1'b1);
    pulses(8'h00);
    far.set_nmi(1'b0);
    pulses(8'h01);
    rd(intc_pkg::ADDR_IRQ_STATUS, 8'h01);
    wr(intc_pkg::ADDR_IRQ_STATUS, 8'h01);
    wr(intc_pkg::ADDR_MODE_CTRL, 8'h08);
    far.set_nmi(1'b1);
    pulses(8'h01);
    far.set_nmi(1'b0);
    pulses(8'h00);
    for (int i = 0; i < 5; i++) begin
      far.fault(i);
      #1 chk({3'h0, acc, alvl}, 8'h18);
    end
    $display("test nmi done");
  endtask
  task automatic t_prio;
    logic [7:0] w[6] = '{8'hB3, 8'hB4, 8'hF7, 8'h87, 8'h07, 8'h80};
    logic [7:0] e[6] = '{8'h0E, 8'h1F, 8'h1E, 8'h1F, 8'h00, 8'h00};
    far.set_dma(12'h688);
    for (int i = 0; i < 6; i++) begin
      wr(intc_pkg::ADDR_CPU_PRIO, w[i]);
      #1 chk({3'h0, od, ox}, e[i]);
      chk({1'b0, xlvl, 1'b0, clvl}, w[i] & 8'h77);
      rd(intc_pkg::ADDR_ARB_STATE, e[i]);
    end
    $display("test prio done");
  endtask
  task automatic t_auto;
    far.set_mask(1'b1, 3'h5);
    wr(intc_pkg::ADDR_CPU_PRIO, 8'h88);
    repeat (2) @(posedge clk);
    #1 chk({5'h00, clvl}, 8'h07);
    wr(intc_pkg::ADDR_MODE_CTRL, 8'h20);
    repeat (2) @(posedge clk);
    #1 chk({5'h00, clvl}, 8'h05);
    wr(intc_pkg::ADDR_CPU_PRIO, 8'h8B);
    rd(intc_pkg::ADDR_CPU_PRIO, 8'h8D);
    far.set_mask(1'b1, 3'h2);
    repeat (2) @(posedge clk);
    #1 chk({5'h00, clvl}, 8'h02);
    wr(intc_pkg::ADDR_CPU_PRIO, 8'h84);
    #1 chk({5'h00, clvl}, 8'h02);
    // auto is clear by now, so this second write lands
    wr(intc_pkg::ADDR_CPU_PRIO, 8'h84);
    far.set_mask(1'b0, 3'h6);
    repeat (2) @(posedge clk);
    #1 chk({5'h00, clvl}, 8'h04);
    $display("test auto done");
  endtask
  task automatic results;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_mode();
    t_irq();
    t_nmi();
    t_prio();
    t_auto();
    results();
  end
  // a hang anywhere ends the run as a failure
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule
